// file: tbaf_pkg.sv
// Shared constants and types for the trigger block acquisition buffer.
// Assumes a single 20 MHz clock domain and synchronous active-low reset.
package tbaf_pkg;
	localparam int SCAN_W       = 32;   // Scan word width
	localparam int MEM_DEPTH    = 64;   // Scan and descriptor slots
	localparam int ADDR_W       = 6;    // Slot index width
	localparam int DESC_SLOTS   = 1;    // Slots each block descriptor costs
	localparam int MAX_BLOCKS   = 8;    // Descriptor table depth
	localparam int BLK_W        = 3;    // Descriptor index width
	localparam int PTR_W        = 24;   // Logical pointer width
	localparam int CNT_W        = 16;   // Count width
	localparam int THRESH_PCT   = 75;   // Fill threshold percentage
	localparam logic [PTR_W-1:0] PTR_UNDEF = 24'hF0BDC1; // -999999
	localparam logic [1:0] BST_ACQ  = 2'h0; // Block still acquiring
	localparam logic [1:0] BST_DONE = 2'h1; // Ended normally
	localparam logic [1:0] BST_ABRT = 2'h2; // Ended by user
	// Read quantity selected by the read command suffix
	typedef enum logic [1:0] {
		RQ_SCAN  = 2'h1,
		RQ_BLOCK = 2'h2,
		RQ_ALL   = 2'h3
	} tbaf_rq_t;
	// Per-block descriptor
	typedef struct packed {
		logic [PTR_W-1:0] trig_pos;   // Physical count before trigger
		logic [PTR_W-1:0] stop_ptr;   // Logical stop position
		logic [PTR_W-1:0] end_ptr;    // Logical end position
		logic [CNT_W-1:0] written;    // Scans written
		logic [1:0]       status;     // Block status code
		logic             stop_seen;  // Block end recorded
	} tbaf_desc_t;
endpackage

// file: tbaf_mem_if.sv
// Interface joining the controller to its scan storage.
// Assumes both ends on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface tbaf_mem_if;
	import tbaf_pkg::*;
	logic              wr_en;   // Write one scan
	logic [ADDR_W-1:0] wr_addr; // Write slot
	logic [SCAN_W-1:0] wr_data; // Write data
	logic [ADDR_W-1:0] rd_addr; // Read slot
	logic [SCAN_W-1:0] rd_data; // Combinational read data
	modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
	modport mem  (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface
`default_nettype wire

// file: tbaf_scan_mem.sv
// Flip-flop scan storage, one write port and one read port.
// Assumes the controller never writes a slot that is unread.
`timescale 1ns/1ns
`default_nettype none
module tbaf_scan_mem
	import tbaf_pkg::*;
(
	// Clock
	input  wire logic clk,
	// Storage port
	tbaf_mem_if.mem   mp
);
	logic [SCAN_W-1:0] store [MEM_DEPTH]; // Scan slots

	// Write one slot
	always_ff @(posedge clk) begin
		if (mp.wr_en) begin
			store[mp.wr_addr] <= mp.wr_data;
		end
	end

	// Read by index
	assign mp.rd_data = store[mp.rd_addr];
endmodule
`default_nettype wire

// file: tbaf_ctrl.sv
// Trigger block acquisition buffer controller and status reporter.
// Assumes scan, trigger and stop strobes come from logic on clk;
// the command port is driven by the command decoder on clk.
`timescale 1ns/1ns
`default_nettype none
module tbaf_ctrl
	import tbaf_pkg::*;
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// Acquisition side
	input  wire logic              scan_valid,
	input  wire logic [SCAN_W-1:0] scan_data,
	input  wire logic              trig_event,
	input  wire logic              stop_event,
	input  wire logic [CNT_W-1:0]  pre_count_in,
	input  wire logic [CNT_W-1:0]  post_stop_in,
	input  wire logic              auto_rearm_in,
	input  wire logic              arm_cmd,
	input  wire logic              abort_cmd,
	// Host read and status commands
	input  wire logic              read_req,
	input  wire tbaf_rq_t          read_qty,
	input  wire logic              buffer_status_query,
	// Scan output
	output logic                   out_valid,
	output logic [SCAN_W-1:0]      out_data,
	output logic                   out_last,
	// Status output
	output logic                   stat_valid,
	output logic [CNT_W-1:0]       stat_blocks,
	output logic [CNT_W-1:0]       stat_scans,
	output logic [PTR_W-1:0]       stat_read_ptr,
	output logic [PTR_W-1:0]       stat_stop_ptr,
	output logic [PTR_W-1:0]       stat_end_ptr,
	output logic [1:0]             stat_block_status,
	// Condition flags
	output logic                   armed,
	output logic                   thresh_flag,
	output logic                   trig_overrun,
	output logic                   buf_overrun
);
	// Storage and descriptors
	tbaf_mem_if mif ();
	tbaf_scan_mem u_mem (.clk(clk), .mp(mif));

	tbaf_desc_t        desc [MAX_BLOCKS]; // Block descriptors
	logic [BLK_W-1:0]  rd_blk;            // Oldest unread block
	logic [BLK_W-1:0]  wr_blk;            // Block being written
	logic [CNT_W-1:0]  nblocks;           // Defined blocks
	logic [ADDR_W-1:0] wr_ptr;            // Physical write slot
	logic [ADDR_W-1:0] rd_ptr;            // Physical read slot
	logic [CNT_W-1:0]  used;              // Slots occupied by scans
	logic [CNT_W-1:0]  pretrig;           // Unread pre-trigger scans
	logic [CNT_W-1:0]  avail;             // Readable scans total
	logic [PTR_W-1:0]  rd_log;            // Logical read position
	logic [CNT_W-1:0]  post_left;         // Post-stop scans to go
	logic              in_block;          // Writing a triggered block
	logic              in_post;           // Collecting post-stop scans
	logic              cfg_rearm;         // Frozen auto re-arm flag
	logic [CNT_W-1:0]  cfg_pre;           // Frozen pre-trigger depth
	logic [CNT_W-1:0]  cfg_post;          // Frozen post-stop depth
	logic [1:0]        mode;              // Active read quantity
	logic              reading;           // Read burst running

	// Capacity left after descriptors take their share
	function automatic logic [CNT_W-1:0] cap(input logic [CNT_W-1:0] nb);
		cap = CNT_W'(MEM_DEPTH) - CNT_W'(nb * CNT_W'(DESC_SLOTS));
	endfunction

	// Wrap-around increment of a slot index
	function automatic logic [ADDR_W-1:0] inc(input logic [ADDR_W-1:0] a);
		inc = (a == ADDR_W'(MEM_DEPTH - 1)) ? '0 : a + 1'b1;
	endfunction

	// Block and write strobes
	logic starting;   // Trigger accepted this cycle
	logic cur_done;   // Write block complete
	logic do_write;   // Scan goes to memory
	logic do_read;    // Scan leaves memory
	logic full;       // No room for another scan
	logic rd_blk_end; // Delivered scan is block's last
	logic blk_full;   // Descriptor table exhausted
	logic want_wr;    // Scan the block framing would keep

	assign full     = (used + 1'b1) > cap(nblocks);
	assign blk_full = nblocks == CNT_W'(MAX_BLOCKS);
	// only a start event opens a block
	assign starting = trig_event && armed && !in_block && !blk_full
		&& (used + 1'b1) <= cap(nblocks + 1'b1);
	assign cur_done = in_post && (post_left == '0);
	// pre-trigger scans only while armed, up to depth
	assign want_wr  = scan_valid && !cur_done && (in_block || starting
		|| (armed && pretrig < cfg_pre));
	assign do_write = want_wr && !full;
	assign do_read  = reading && avail != '0;
	assign rd_blk_end = do_read
		&& rd_log == desc[rd_blk].end_ptr && desc[rd_blk].stop_seen
		&& in_block == 1'b0 | rd_blk != wr_blk;

	// Memory port wiring
	// strictly sequential slots
	assign mif.wr_en   = do_write;
	assign mif.wr_addr = wr_ptr;
	assign mif.wr_data = scan_data;
	// oldest slot is always the read slot
	assign mif.rd_addr = rd_ptr;

	// Arming and frozen configuration
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			armed     <= 1'b0;
			cfg_rearm <= 1'b0;
			cfg_pre   <= '0;
			cfg_post  <= '0;
		end else if (arm_cmd && !(cfg_rearm && in_block)) begin
			armed     <= !in_block;
			cfg_rearm <= auto_rearm_in;
			cfg_pre   <= pre_count_in;
			cfg_post  <= post_stop_in;
		end else if (starting) begin
			armed <= 1'b0;
		end else if (cur_done && cfg_rearm) begin
			armed <= 1'b1;
		end
	end

	// Write side: block framing
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			in_block  <= 1'b0;
			in_post   <= 1'b0;
			post_left <= '0;
			wr_blk    <= '0;
		end else if (starting) begin
			// block opens at the trigger scan
			in_block <= 1'b1;
			in_post  <= 1'b0;
			wr_blk   <= (nblocks == '0) ? rd_blk : wr_blk + 1'b1;
		end else if (in_block && (cur_done || abort_cmd)) begin
			in_block <= 1'b0;
			in_post  <= 1'b0;
		end else if (in_block && stop_event && !in_post) begin
			in_post   <= 1'b1;
			post_left <= cfg_post;
		end else if (in_post && do_write) begin
			post_left <= post_left - 1'b1;
		end
	end

	// Trigger overrun flag, cleared by re-arm command
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			trig_overrun <= 1'b0;
		end else if (trig_event && in_block) begin
			trig_overrun <= 1'b1;
		end else if (arm_cmd) begin
			trig_overrun <= 1'b0;
		end
	end

	// Buffer overrun flag, cleared by re-arm command
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			buf_overrun <= 1'b0;
		end else if ((want_wr && full) || (trig_event && armed
			&& !in_block && !starting)) begin
			buf_overrun <= 1'b1;
		end else if (arm_cmd) begin
			buf_overrun <= 1'b0;
		end
	end

	// Descriptor updates
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < MAX_BLOCKS; i++) begin
				desc[i] <= '0;
			end
		end else begin
			if (starting) begin
				desc[(nblocks == '0) ? rd_blk : wr_blk + 1'b1] <= '{
					trig_pos: PTR_W'(pretrig), stop_ptr: PTR_UNDEF,
					end_ptr: PTR_UNDEF, written: CNT_W'(1),
					status: BST_ACQ, stop_seen: 1'b0};
			end else if (in_block) begin
				if (do_write) begin
					desc[wr_blk].written <= desc[wr_blk].written + 1'b1;
				end
				if (stop_event && !in_post) begin
					desc[wr_blk].stop_ptr <=
						PTR_W'(desc[wr_blk].written) - 1'b1;
				end
				if (cur_done || abort_cmd) begin
					desc[wr_blk].status <= cur_done ? BST_DONE : BST_ABRT;
					desc[wr_blk].stop_seen <= 1'b1;
					desc[wr_blk].end_ptr <=
						PTR_W'(desc[wr_blk].written) - 1'b1;
				end
			end
		end
	end

	// Scan occupancy, pointers and block count
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr  <= '0;
			rd_ptr  <= '0;
			used    <= '0;
			pretrig <= '0;
			avail   <= '0;
			nblocks <= '0;
			rd_blk  <= '0;
			rd_log  <= PTR_UNDEF;
		end else begin
			if (do_write) begin
				wr_ptr <= inc(wr_ptr);
			end
			if (do_read) begin
				rd_ptr <= inc(rd_ptr);
			end
			used <= used + CNT_W'(do_write) - CNT_W'(do_read);
			if (starting) begin
				pretrig <= '0;
				avail   <= avail + pretrig + CNT_W'(do_write)
					- CNT_W'(do_read);
			end else if (do_write && !in_block) begin
				pretrig <= pretrig + 1'b1;
				avail   <= avail - CNT_W'(do_read);
			end else begin
				avail   <= avail + CNT_W'(do_write && in_block)
					- CNT_W'(do_read);
			end
			// advance to the next stacked block
			// pointer stays on oldest unread block
			if (rd_blk_end) begin
				rd_blk  <= rd_blk + 1'b1;
				nblocks <= nblocks - CNT_W'(!starting);
				rd_log  <= (nblocks > CNT_W'(1))
					? -PTR_W'(desc[rd_blk + 1'b1].trig_pos)
					: starting ? -PTR_W'(pretrig) : PTR_UNDEF;
			end else begin
				nblocks <= nblocks + CNT_W'(starting);
				// pointer steps by one per scan
				if (do_read) begin
					rd_log <= rd_log + 1'b1;
				// first scan sits at minus the pre-trigger scan count
				end else if (starting && nblocks == '0) begin
					rd_log <= -PTR_W'(pretrig);
				end
			end
		end
	end

	// Read burst control
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reading <= 1'b0;
			mode    <= RQ_SCAN;
		end else if (read_req && !reading) begin
			reading <= 1'b1;
			mode    <= read_qty;
		end else if (reading) begin
			case (mode)
				RQ_SCAN:  reading <= !do_read && avail != '0;
				RQ_BLOCK: reading <= !rd_blk_end && avail != '0;
				RQ_ALL:   reading <= avail > CNT_W'(do_read);
				default:  reading <= 1'b0;
			endcase
		end
	end

	// Scan output register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			out_data  <= '0;
			out_last  <= 1'b0;
		end else begin
			out_valid <= do_read;
			out_data  <= do_read ? mif.rd_data : out_data;
			out_last  <= do_read && (mode == RQ_SCAN || rd_blk_end
				|| avail == CNT_W'(1));
		end
	end

	// Status report of the current read block
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stat_valid        <= 1'b0;
			stat_blocks       <= '0;
			stat_scans        <= '0;
			stat_read_ptr     <= PTR_UNDEF;
			stat_stop_ptr     <= PTR_UNDEF;
			stat_end_ptr      <= PTR_UNDEF;
			stat_block_status <= BST_ACQ;
		end else begin
			stat_valid <= buffer_status_query;
			if (buffer_status_query) begin
				stat_blocks   <= nblocks;
				stat_scans    <= avail;
				stat_read_ptr <= (nblocks == '0) ? PTR_UNDEF : rd_log;
				stat_stop_ptr <= (nblocks == '0) ? PTR_UNDEF
					: desc[rd_blk].stop_ptr;
				stat_end_ptr  <= (nblocks == '0) ? PTR_UNDEF
					: desc[rd_blk].end_ptr;
				stat_block_status <= (nblocks == '0) ? BST_ACQ
					: desc[rd_blk].status;
			end
		end
	end

	// Fill threshold flag
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			thresh_flag <= 1'b0;
		end else begin
			thresh_flag <= (32'(used) * 100) >=
				(32'(cap(nblocks)) * THRESH_PCT);
		end
	end
endmodule
`default_nettype wire

// file: tbaf_chk.sv
// Port assertions for the acquisition buffer controller.
// Assumes one clock domain with synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module tbaf_chk
	import tbaf_pkg::*;
(
	// Clock and reset
	input wire logic             clk,
	input wire logic             rst_n,
	// Causes
	input wire logic             scan_valid,
	input wire logic             trig_event,
	input wire logic             arm_cmd,
	input wire logic             buffer_status_query,
	// Effects
	input wire logic             armed,
	input wire logic             out_valid,
	input wire logic             out_last,
	input wire logic             stat_valid,
	input wire logic [PTR_W-1:0] stat_read_ptr,
	input wire logic             thresh_flag,
	input wire logic             trig_overrun,
	input wire logic             buf_overrun
);
	// All checks on the rising edge, idle in reset
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	AST_STAT_ANSWER: assert property (
		buffer_status_query |=> stat_valid)
		else $error("status answer missing");
	AST_STAT_CAUSE: assert property (
		stat_valid |-> $past(buffer_status_query))
		else $error("status answer without query");
	AST_STAT_HOLD: assert property (
		!stat_valid |-> $stable(stat_read_ptr))
		else $error("read pointer report moved without query");
	AST_LAST_VALID: assert property (out_last |-> out_valid)
		else $error("last flag without scan");
	AST_TOVR_CAUSE: assert property (
		$rose(trig_overrun) |-> $past(trig_event))
		else $error("trigger overrun without trigger");
	AST_TOVR_STICKY: assert property (
		trig_overrun && !arm_cmd |=> trig_overrun)
		else $error("trigger overrun dropped");
	AST_BOVR_STICKY: assert property (
		buf_overrun && !arm_cmd |=> buf_overrun)
		else $error("buffer overrun dropped");
	AST_BOVR_CAUSE: assert property (
		$rose(buf_overrun) |-> $past(scan_valid) || $past(trig_event))
		else $error("buffer overrun without write");
	// A refused trigger leaves armed set but raises the buffer overrun
	AST_ONE_TRIG: assert property (
		trig_event && armed && !arm_cmd |=> !armed || buf_overrun)
		else $error("still armed after trigger");
	// Occupancy lands one edge after the write, the flag one edge later
	AST_THRESH: assert property (
		$rose(thresh_flag) |-> $past(scan_valid, 2) || $past(trig_event, 2))
		else $error("threshold rose without write");
endmodule
bind tbaf_ctrl tbaf_chk u_chk (.clk, .rst_n, .scan_valid, .trig_event,
	.arm_cmd, .buffer_status_query, .armed, .out_valid, .out_last,
	.stat_valid, .stat_read_ptr, .thresh_flag, .trig_overrun,
	.buf_overrun);
`default_nettype wire

// file: tbaf_host.sv
// Controlling computer model: read and status commands.
// Assumes commands are sampled on the rising edge of clk.
`timescale 1ns/1ns
`default_nettype none
module tbaf_host
	import tbaf_pkg::*;
(
	// Clock
	input  wire logic              clk,
	// Commands
	output var logic               read_req,
	output var tbaf_rq_t           read_qty,
	output var logic               buffer_status_query,
	// Answers
	input  wire logic              out_valid,
	input  wire logic [SCAN_W-1:0] out_data,
	input  wire logic              out_last,
	input  wire logic              stat_valid
);
	logic [SCAN_W-1:0] got[$]; // Scans of the last read
	bit                stat_ok; // Status answer seen

	// Idle commands from time zero
	initial begin
		read_req = 1'b0;
		read_qty = RQ_SCAN;
		buffer_status_query = 1'b0;
	end

	task automatic rd(input tbaf_rq_t q);
		got.delete();
		read_qty = q;
		read_req = 1'b1;
		@(posedge clk) #2;
		read_req = 1'b0;
		for (int n = 0; n < 200; n++) begin
			@(posedge clk) #2;
			// Keep each delivered scan
			if (out_valid === 1'b1) begin
				got.push_back(out_data);
				if (out_last === 1'b1)
					break;
			end
		end
	endtask

	task automatic query();
		stat_ok = 1'b0;
		buffer_status_query = 1'b1;
		@(posedge clk) #2;
		buffer_status_query = 1'b0;
		for (int n = 0; n < 4 && !stat_ok; n++) begin
			stat_ok = (stat_valid === 1'b1);
			if (!stat_ok)
				@(posedge clk) #2;
		end
	endtask
endmodule
`default_nettype wire

// file: tbaf_ctrl_tb.sv
// Self-checking bench for the acquisition buffer controller.
// Assumes the host model drives reads and status queries.
`timescale 1ns/1ns
`default_nettype none
module tbaf_ctrl_tb;
	import tbaf_pkg::*;
	logic clk, rst_n, scan_valid, trig_event, stop_event;
	logic auto_rearm_in, arm_cmd, abort_cmd, read_req;
	logic buffer_status_query, out_valid, out_last, stat_valid;
	logic armed, thresh_flag, trig_overrun, buf_overrun;
	logic [SCAN_W-1:0] scan_data, out_data;
	logic [CNT_W-1:0]  pre_count_in, post_stop_in;
	logic [CNT_W-1:0]  stat_blocks, stat_scans;
	logic [PTR_W-1:0]  stat_read_ptr, stat_stop_ptr, stat_end_ptr;
	logic [1:0]        stat_block_status;
	tbaf_rq_t          read_qty;
	int                fail_count = 0;
	int                check_count = 0;

	tbaf_ctrl DUT (.*);
	tbaf_host host (.*);

	// Clock at 20 MHz
	initial clk = 1'b0;
	always #25 clk = ~clk;

	task automatic tk(input int n = 1);
		repeat (n) @(posedge clk) #2;
	endtask

	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Verdict and stop
	task automatic end_of_test();
		if (fail_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic arm(input logic [15:0] pre, ps, input logic a);
		pre_count_in = pre;
		post_stop_in = ps;
		auto_rearm_in = a;
		arm_cmd = 1'b1;
		tk();
		arm_cmd = 1'b0;
		tk();
	endtask

	task automatic scan(input logic [31:0] d, input logic t);
		scan_valid = 1'b1;
		scan_data = d;
		trig_event = t;
		tk();
		scan_valid = 1'b0;
		trig_event = 1'b0;
		tk();
	endtask

	task automatic ev(input logic s, a, t);
		stop_event = s;
		abort_cmd = a;
		trig_event = t;
		tk();
		{stop_event, abort_cmd, trig_event} = 3'h0;
		tk();
	endtask

	task automatic stat(int b, int s, logic [23:0] p, sp, ep,
		logic [1:0] st);
		host.query();
		chk("stat_valid", 1, 32'(host.stat_ok));
		chk("stat_blocks", b, 32'(stat_blocks));
		chk("stat_scans", s, 32'(stat_scans));
		chk("stat_read_ptr", 32'(p), 32'(stat_read_ptr));
		chk("stat_stop_ptr", 32'(sp), 32'(stat_stop_ptr));
		chk("stat_end_ptr", 32'(ep), 32'(stat_end_ptr));
		chk("stat_block_status", 32'(st), 32'(stat_block_status));
	endtask

	// Read and compare a run of consecutive scan words
	task automatic words(tbaf_rq_t q, int n, logic [31:0] base);
		host.rd(q);
		chk("word_count", n, 32'(host.got.size()));
		foreach (host.got[i])
			chk("out_data", base + i, host.got[i]);
	endtask

	// One block with pre-trigger scans, read in pieces
	task automatic sc_block();
		stat(0, 0, PTR_UNDEF, PTR_UNDEF, PTR_UNDEF, BST_ACQ);
		scan(32'h0FF, 1'b0);
		arm(16'h2, 16'h1, 1'b0);
		scan(32'h100, 1'b0);
		scan(32'h101, 1'b0);
		scan(32'h102, 1'b1);
		scan(32'h103, 1'b0);
		stat(1, 4, 24'hFFFFFE, PTR_UNDEF, PTR_UNDEF, BST_ACQ);
		words(RQ_SCAN, 1, 32'h100);
		stat(1, 3, 24'hFFFFFF, PTR_UNDEF, PTR_UNDEF, BST_ACQ);
		ev(1'b1, 1'b0, 1'b0);
		scan(32'h104, 1'b0);
		stat(1, 4, 24'hFFFFFF, 24'h1, 24'h2, BST_DONE);
		chk("armed", 0, 32'(armed));
		words(RQ_ALL, 4, 32'h101);
		stat(0, 0, PTR_UNDEF, PTR_UNDEF, PTR_UNDEF, BST_ACQ);
	endtask

	// Auto re-arm, block reads, trigger overrun, abort
	task automatic sc_rearm();
		arm(16'h0, 16'h0, 1'b1);
		scan(32'h200, 1'b1);
		scan(32'h201, 1'b0);
		ev(1'b1, 1'b0, 1'b0);
		tk(2);
		scan(32'h300, 1'b1);
		ev(1'b1, 1'b0, 1'b0);
		stat(2, 3, 24'h0, 24'h1, 24'h1, BST_DONE);
		chk("armed", 1, 32'(armed));
		words(RQ_BLOCK, 2, 32'h200);
		words(RQ_SCAN, 1, 32'h300);
		tk(2);
		scan(32'h400, 1'b1);
		ev(1'b0, 1'b0, 1'b1);
		chk("trig_overrun", 1, 32'(trig_overrun));
		ev(1'b0, 1'b1, 1'b0);
		stat(1, 1, 24'h0, PTR_UNDEF, 24'h0, BST_ABRT);
		arm(16'h0, 16'h0, 1'b0);
		chk("trig_overrun", 0, 32'(trig_overrun));
		words(RQ_ALL, 1, 32'h400);
	endtask

	// Fill until refused, no unread scan lost
	task automatic sc_full();
		scan(32'h500, 1'b1);
		for (int i = 1; i < 70; i++)
			scan(32'h500 + i, 1'b0);
		chk("buf_overrun", 1, 32'(buf_overrun));
		chk("thresh_flag", 1, 32'(thresh_flag));
		words(RQ_ALL, MEM_DEPTH - DESC_SLOTS, 32'h500);
	endtask

	// Main sequence
	initial begin
		{scan_valid, trig_event, stop_event, arm_cmd, abort_cmd} = 5'h0;
		{auto_rearm_in, pre_count_in, post_stop_in} = 33'h0;
		scan_data = 32'h0;
		rst_n = 1'b0;
		repeat (20) @(posedge clk);
		#2 rst_n = 1'b1;
		sc_block();
		sc_rearm();
		sc_full();
		end_of_test();
	end

	// Watchdog against a hang
	initial begin
		#(50 * 8000);
		fail_count++;
		end_of_test();
	end
endmodule
`default_nettype wire
